// ### src/spmc_pkg.sv
`default_nettype none
package spmc_pkg;
    // Register offsets
    localparam logic [7:0] SPMC_TXR_OFS = 8'h29;
    localparam logic [7:0] SPMC_RXR_OFS = 8'h2A;
    localparam logic [7:0] SPMC_CR_OFS = 8'h2B;
    localparam logic [7:0] SPMC_CFG_OFS = 8'h2C;
    // Control/status bit positions
    localparam int SPMC_CR_LSB = 7;
    localparam int SPMC_CR_OVR = 6;
    localparam int SPMC_CR_CMP = 5;
    localparam int SPMC_CR_TXE = 4;
    localparam int SPMC_CR_RXF = 3;
    localparam int SPMC_CR_CPHA = 2;
    localparam int SPMC_CR_CPOL = 1;
    localparam int SPMC_CR_EN = 0;
    // Configuration bit positions
    localparam int SPMC_CFG_SEL_HI = 7;
    localparam int SPMC_CFG_SEL_LO = 5;
    localparam int SPMC_CFG_BYP = 4;
    localparam int SPMC_CFG_SSV = 3;
    localparam int SPMC_CFG_SSEN_N = 2;
    localparam int SPMC_CFG_INTSEL = 1;
    localparam int SPMC_CFG_SLAVE = 0;
    // Reset values
    localparam logic [7:0] SPMC_CFG_RST = 8'h00;
    localparam logic [7:0] SPMC_BYTE_RST = 8'h00;
    // Pin synchroniser width: ss_n, sclk, mosi, miso
    localparam int SPMC_SYNC_W = 4;
    // One byte is 16 serial clock edges
    localparam logic [3:0] SPMC_LAST_EDGE = 4'hF;
    localparam logic [3:0] SPMC_FIRST_EDGE = 4'h0;
    localparam logic [7:0] SPMC_DIV_ONE = 8'h01;
    typedef enum logic [1:0] {
        SPMC_IDLE = 2'b01,
        SPMC_RUN = 2'b10
    } spmc_state_type;
endpackage : spmc_pkg
`default_nettype wire

// ### src/spmc_sync.sv
`default_nettype none
module spmc_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic bypass,
    // Data
    input wire logic [W-1:0] raw_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] stab_q;

    // First stage feeds only the second stage
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            stab_q <= '0;
        end
        else
        begin
            meta_q <= raw_in;
            stab_q <= meta_q;
        end
    end

    assign sync_out = bypass ? raw_in : stab_q;
endmodule : spmc_sync
`default_nettype wire

// ### src/spmc_core.sv
// Functional notes
// - Modes 0 to 3 work as master and as slave.
// - MSb goes first by default; a control bit selects LSb first.
// - Master shifts in from MISO, out on MOSI; separate tx/rx bytes.
// - Input bit is latched on the edge opposite the shifting edge.
// - Master makes the bit clock from the selected clock source.
// - Master never drives slave select; software handles it.
// - Writing receive buffer does nothing; transmit buffer reads zero.
// - Interrupt is tx-empty or complete, select bit, tx-empty after reset.
// - Complete interrupt stays until control/status read, master load or slave select falling.
// - Slave shifts only on incoming serial clock; master starts all.
// - Slave takes part only while its active-low select is low.
// - Modes 0 and 2 slave loads next byte on select falling.
// - Slave select comes from pin or from a software bit.
// - Deselected slave ignores inputs, resets state, drives MISO high.
// - Pin inputs pass two flops unless the bypass bit is set.
// - Idle master loads written byte next edge and starts.
// - Writing tx buffer clears tx-empty; loading shifter sets it.
// - Finished byte goes to receive buffer and sets rx-full.
// - Reading receive buffer clears rx-full.
// - Tx and rx data registers and control/status are one byte each.
// - A byte is eight bits with eight clocks, both ways at once.
// - Phase 0 changes data on trailing edge; polarity sets idle level.
// - Overrun sets when a byte lands before the previous was read.
// - Complete reads 0 during transfer, 1 after, clears on read.
`default_nettype none
module spmc_core
    import spmc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Block interrupt
    output logic int_out,
    // Serial pins
    input wire logic ss_n_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    output logic sclk_out,
    output logic mosi_out,
    output logic miso_out
);
    import spmc_pkg::*;

    function automatic logic [7:0] shift_in(input logic [7:0] sh,
        input logic b, input logic lsb);
        shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction : shift_in

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    logic lsb_q, cpha_q, cpol_q, en_q;
    logic ovr_q, cmp_q, txe_q, rxf_q;
    logic [7:0] cfg_q;
    logic [7:0] tx_hold_q, rx_hold_q, sh_q, rdata_q, div_q;
    logic rxd_q, sclk_q, sclk_prev_q, ss_prev_q;
    logic [3:0] edge_q;
    spmc_state_type st_q, st_d;
    logic [SPMC_SYNC_W-1:0] pins_s;
    logic s_ss_n, s_sclk, s_mosi, s_miso;
    logic slave, ss_n_eff, sel_act, in_bit, out_bit;
    logic m_tick, s_edge, ev, lead, trail, samp, shft, last, done;
    logic ss_fall, m_load, s_load, load;
    logic wr_tx, wr_cr, wr_cfg, rd_rx, rd_cr;
    logic [7:0] load_data, final_byte, half, rd_mux;

    // Two-stage synchroniser with bypass
    spmc_sync #(.W(SPMC_SYNC_W)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .bypass(cfg_q[SPMC_CFG_BYP]),
        .raw_in({ss_n_in, sclk_in, mosi_in, miso_in}),
        .sync_out(pins_s)
    );
    assign {s_ss_n, s_sclk, s_mosi, s_miso} = pins_s;

    // Register decode
    assign wr_tx = reg_wr && hit(reg_addr, SPMC_TXR_OFS);
    assign wr_cr = reg_wr && hit(reg_addr, SPMC_CR_OFS);
    assign wr_cfg = reg_wr && hit(reg_addr, SPMC_CFG_OFS);
    assign rd_rx = reg_rd && hit(reg_addr, SPMC_RXR_OFS);
    assign rd_cr = reg_rd && hit(reg_addr, SPMC_CR_OFS);

    // Role and select
    assign slave = cfg_q[SPMC_CFG_SLAVE];
    assign ss_n_eff = cfg_q[SPMC_CFG_SSEN_N] ? s_ss_n
        : cfg_q[SPMC_CFG_SSV];
    assign sel_act = slave && en_q && !ss_n_eff;
    assign in_bit = slave ? s_mosi : s_miso;
    assign out_bit = lsb_q ? sh_q[0] : sh_q[7];

    // Bit clock divider: half period of 2^sel system clocks
    assign half = SPMC_DIV_ONE << cfg_q[SPMC_CFG_SEL_HI:SPMC_CFG_SEL_LO];
    assign m_tick = !slave && (st_q == SPMC_RUN)
        && (div_q == half - SPMC_DIV_ONE);
    // Slave edges come only from the incoming clock while selected
    assign s_edge = sel_act && (s_sclk != sclk_prev_q);
    assign ev = slave ? s_edge : m_tick;
    assign lead = ev && !edge_q[0];
    assign trail = ev && edge_q[0];
    // Phase picks sampling and shifting edges
    assign samp = cpha_q ? trail : lead;
    assign shft = cpha_q ? (lead && edge_q != SPMC_FIRST_EDGE) : trail;
    assign last = trail && (edge_q == SPMC_LAST_EDGE);
    assign done = last;
    // Phase 1 samples the final bit on the closing edge itself
    assign final_byte = cpha_q ? shift_in(sh_q, in_bit, lsb_q)
        : shift_in(sh_q, rxd_q, lsb_q);

    // Loading the shifter
    assign ss_fall = slave && en_q && ss_prev_q && !ss_n_eff;
    assign m_load = !slave && en_q && (st_q == SPMC_IDLE)
        && !txe_q;
    assign s_load = slave && en_q && (cpha_q
        ? (sel_act && lead && edge_q == SPMC_FIRST_EDGE)
        : (ss_fall || (sel_act && last)));
    assign load = m_load || s_load;
    // A write landing on a load goes straight to the shifter
    assign load_data = wr_tx ? reg_wdata : tx_hold_q;

    always_comb
    begin
        st_d = st_q;
        if (!en_q)
            st_d = SPMC_IDLE;
        else if (slave)
            st_d = sel_act ? SPMC_RUN : SPMC_IDLE;
        else
        begin
            unique case (st_q)
                SPMC_IDLE:
                    if (m_load)
                        st_d = SPMC_RUN;
                SPMC_RUN:
                    if (last)
                        st_d = SPMC_IDLE;
                default:
                    st_d = SPMC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            st_q <= SPMC_IDLE;
        else
            st_q <= st_d;
    end

    // Divider and master bit clock
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            div_q <= SPMC_BYTE_RST;
            sclk_q <= 1'b0;
        end
        else if (st_q != SPMC_RUN || slave)
        begin
            div_q <= SPMC_BYTE_RST;
            sclk_q <= cpol_q;
        end
        else if (m_tick)
        begin
            div_q <= SPMC_BYTE_RST;
            sclk_q <= !sclk_q;
        end
        else
            div_q <= div_q + SPMC_DIV_ONE;
    end

    // Edge counter, reset while deselected
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            edge_q <= SPMC_FIRST_EDGE;
        else if (!en_q || (slave && !sel_act) || m_load)
            edge_q <= SPMC_FIRST_EDGE;
        else if (ev)
            edge_q <= edge_q + 4'h1;
    end

    // Input latch and shifter
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rxd_q <= 1'b0;
            sh_q <= SPMC_BYTE_RST;
        end
        else
        begin
            if (samp)
                rxd_q <= in_bit;
            if (load)
                sh_q <= load_data;
            else if (shft && !last)
                sh_q <= shift_in(sh_q, rxd_q, lsb_q);
        end
    end

    // Edge and select history, fed from the synchroniser output and ss_n_eff
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            sclk_prev_q <= 1'b0;
            ss_prev_q <= 1'b1;
        end
        else
        begin
            sclk_prev_q <= s_sclk;
            ss_prev_q <= ss_n_eff;
        end
    end

    // Data registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            tx_hold_q <= SPMC_BYTE_RST;
            rx_hold_q <= SPMC_BYTE_RST;
        end
        else
        begin
            if (wr_tx)
                tx_hold_q <= reg_wdata;
            if (done)
                rx_hold_q <= final_byte;
        end
    end

    // Control and configuration
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            {lsb_q, cpha_q, cpol_q, en_q} <= 4'h0;
            cfg_q <= SPMC_CFG_RST;
        end
        else
        begin
            if (wr_cr)
            begin
                lsb_q <= reg_wdata[SPMC_CR_LSB];
                cpha_q <= reg_wdata[SPMC_CR_CPHA];
                cpol_q <= reg_wdata[SPMC_CR_CPOL];
                en_q <= reg_wdata[SPMC_CR_EN];
            end
            if (wr_cfg)
                cfg_q <= reg_wdata;
        end
    end

    // Status flags; a set always beats a clear
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            txe_q <= 1'b1;
            rxf_q <= 1'b0;
            ovr_q <= 1'b0;
            cmp_q <= 1'b0;
        end
        else
        begin
            if (load)
                txe_q <= 1'b1;
            else if (wr_tx)
                txe_q <= 1'b0;
            if (done)
                rxf_q <= 1'b1;
            else if (rd_rx)
                rxf_q <= 1'b0;
            if (done && rxf_q && !rd_rx)
                ovr_q <= 1'b1;
            else if (rd_cr)
                ovr_q <= 1'b0;
            if (done)
                cmp_q <= 1'b1;
            else if (rd_cr || m_load || ss_fall)
                cmp_q <= 1'b0;
        end
    end

    // Read mux; transmit buffer and unmapped addresses read zero
    always_comb
    begin
        rd_mux = SPMC_BYTE_RST;
        if (hit(reg_addr, SPMC_RXR_OFS))
            rd_mux = rx_hold_q;
        else if (hit(reg_addr, SPMC_CFG_OFS))
            rd_mux = cfg_q;
        else if (hit(reg_addr, SPMC_CR_OFS))
            rd_mux = {lsb_q, ovr_q, cmp_q, txe_q,
                rxf_q, cpha_q, cpol_q, en_q};
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            rdata_q <= SPMC_BYTE_RST;
        else
            rdata_q <= reg_rd ? rd_mux : SPMC_BYTE_RST;
    end

    // Outputs; no slave-select output, software drives it
    assign reg_rdata = rdata_q;
    assign int_out = cfg_q[SPMC_CFG_INTSEL] ? cmp_q : txe_q;
    assign sclk_out = sclk_q;
    assign mosi_out = out_bit;
    // Idle high lets several slaves share MISO as wired-AND
    assign miso_out = sel_act ? out_bit : 1'b1;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    chk_tx_empty_clear: assert property (
        (wr_tx && !load) |=> !txe_q
    ) else $error("tx empty not cleared by write");

    chk_master_start: assert property (
        m_load |=> (st_q == SPMC_RUN) && txe_q && !cmp_q
            && sh_q == $past(load_data)
    ) else $error("idle master did not start");

    chk_rx_capture: assert property (
        done |=> rxf_q && (rx_hold_q == $past(final_byte))
    ) else $error("finished byte not captured");

    chk_rx_read_clear: assert property (
        (rd_rx && !done) |=> !rxf_q
    ) else $error("rx full not cleared by read");

    chk_overrun_set: assert property (
        (done && rxf_q && !rd_rx) |=> ovr_q
    ) else $error("overrun missed");

    chk_rx_write_ignored: assert property (
        (reg_wr && hit(reg_addr, SPMC_RXR_OFS) && !done)
            |=> $stable(rx_hold_q)
    ) else $error("receive buffer changed by write");

    chk_miso_idle_high: assert property (
        !sel_act |-> miso_out
    ) else $error("deselected slave miso not high");

    chk_slave_state_rst: assert property (
        (slave && !sel_act) |=> st_q == SPMC_IDLE
    ) else $error("deselected slave state not reset");

    chk_sclk_idle_level: assert property (
        (!slave && $past(st_q) == SPMC_IDLE && st_q == SPMC_IDLE)
            |-> sclk_out == $past(cpol_q)
    ) else $error("bit clock idle level wrong");

    chk_complete_irq: assert property (
        (cfg_q[SPMC_CFG_INTSEL] && int_out && !rd_cr && !m_load
            && !ss_fall && !wr_cfg) |=> int_out
    ) else $error("complete interrupt dropped without read");

    chk_read_timing: assert property (
        reg_rd |=> reg_rdata == $past(rd_mux)
    ) else $error("read data not in next cycle");
endmodule : spmc_core
`default_nettype wire

// ### dv/spmc_peer.sv
`default_nettype none
module spmc_peer (
    // Clock
    input wire logic clock,
    // Mode
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb,
    // Design as master
    input wire logic sclk_out,
    input wire logic mosi_out,
    output logic miso_in,
    // Design as slave
    input wire logic miso_out,
    output logic sclk_in,
    output logic mosi_in,
    output logic ss_n_in
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int H = 8;
    int edges = 16;
    int n = 0;
    logic prev_q = 1'h0;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    initial
    begin
        miso_in = 1'h1;
        sclk_in = 1'h0;
        mosi_in = 1'h0;
        ss_n_in = 1'h1;
    end
    function automatic logic pick(input logic [7:0] b, input int k);
        return lsb ? b[k] : b[7-k];
    endfunction : pick
    function automatic logic [7:0] put(input logic [7:0] b, input logic v);
        return lsb ? {v, b[7:1]} : {b[6:0], v};
    endfunction : put
    // Waits first so a polarity change is not counted as an edge
    task arm(input logic [7:0] b);
        repeat (3) @(posedge clock);
        #1;
        tx_q = b;
        n = 0;
        edges = 0;
        miso_in = pick(b, 0);
    endtask : arm
    always @(posedge clock)
    begin
        prev_q <= sclk_out;
        if (edges >= 16)
            miso_in <= ~miso_in; // Toggles every clock, no stale bit
        if (sclk_out !== prev_q && edges < 16)
        begin
            edges = edges + 1;
            if ((sclk_out !== cpol) ^ cpha)
            begin
                rx_q = put(rx_q, mosi_out);
                n = n + 1;
            end
            else if (n < 8)
                miso_in <= pick(tx_q, n);
        end
    end
    // Master towards the design, select low for the whole byte
    task master_byte(input logic [7:0] b, output logic [7:0] got);
        sclk_in <= cpol;
        repeat (H) @(posedge clock);
        ss_n_in <= 1'h0;
        mosi_in <= pick(b, 0);
        repeat (H) @(posedge clock);
        for (int k = 0; k < 8; k++)
        begin
            sclk_in <= ~cpol;
            if (!cpha)
                got = put(got, miso_out);
            else if (k > 0)
                mosi_in <= pick(b, k);
            repeat (H) @(posedge clock);
            sclk_in <= cpol;
            if (cpha)
                got = put(got, miso_out);
            else if (k < 7)
                mosi_in <= pick(b, k + 1);
            repeat (H) @(posedge clock);
        end
        ss_n_in <= 1'h1;
        mosi_in <= ~mosi_in;
    endtask : master_byte
endmodule : spmc_peer
`default_nettype wire

// ### dv/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import spmc_pkg::*;
    localparam int LIMIT = 10000;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_rdata;
    logic int_out, sclk_out, mosi_out, miso_out;
    logic ss_n_in, sclk_in, mosi_in, miso_in;
    logic cpol = 1'h0;
    logic cpha = 1'h0;
    logic lsb = 1'h0;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 7345;
    logic [7:0] exp_q[$];
    logic [7:0] last_rx;
    always #5 clock = ~clock;
    spmc_core u_spmc_core (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_out(int_out),
        .ss_n_in(ss_n_in), .sclk_in(sclk_in), .mosi_in(mosi_in),
        .miso_in(miso_in), .sclk_out(sclk_out), .mosi_out(mosi_out),
        .miso_out(miso_out));
    spmc_peer u_spmc_peer (.clock(clock), .cpol(cpol), .cpha(cpha),
        .lsb(lsb), .sclk_out(sclk_out), .mosi_out(mosi_out),
        .miso_in(miso_in), .miso_out(miso_out), .sclk_in(sclk_in),
        .mosi_in(mosi_in), .ss_n_in(ss_n_in));
    task final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    task check(input string s, input logic [7:0] v, input logic [7:0] e);
        num_checks++;
        if (v !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, v);
        end
    endtask : check
    task c1(input string s, input logic v, input logic e);
        check(s, {7'h0, v}, {7'h0, e});
    endtask : c1
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        #1;
        check("reg_rdata", reg_rdata, e);
    endtask : rchk
    task wait_int;
        int k;
        k = 0;
        @(posedge clock);
        #1;
        while (int_out !== 1'h1 && k < 1000)
        begin
            @(posedge clock);
            #1;
            k++;
        end
        // One more edge so the peer has counted the closing edge
        @(posedge clock);
        #1;
        c1("int_out", int_out, 1'h1);
    endtask : wait_int
    task mx(input int i, input logic rdx, input logic ovr);
        logic [7:0] tb;
        logic [7:0] sb;
        logic [7:0] cr;
        tb = $random(seed);
        sb = $random(seed);
        cpol = i[1];
        cpha = i[0];
        lsb = i[2];
        cr = {lsb, 4'h0, cpha, cpol, 1'h1};
        wr(SPMC_CR_OFS, 8'h00);
        wr(SPMC_CFG_OFS, {3'h3, i[0], 4'h6});
        wr(SPMC_CR_OFS, cr);
        u_spmc_peer.arm(sb);
        exp_q.push_back(sb);
        wr(SPMC_TXR_OFS, tb);
        wait_int();
        c1("sclk_idle", sclk_out, cpol);
        check("edges", u_spmc_peer.edges[7:0], 8'h10);
        check("mosi_byte", u_spmc_peer.rx_q, tb);
        rchk(SPMC_CR_OFS, {cr[7], ovr, 3'h7, cr[2:0]});
        @(posedge clock);
        #1;
        c1("int_clear", int_out, 1'h0);
        if (rdx)
        begin
            last_rx = exp_q[$];
            exp_q.delete();
            rchk(SPMC_RXR_OFS, last_rx);
            rchk(SPMC_CR_OFS, {cr[7], 4'h2, cr[2:0]});
        end
    endtask : mx
    task sx(input int i);
        logic [7:0] tb;
        logic [7:0] mb;
        logic [7:0] got;
        tb = $random(seed);
        mb = $random(seed);
        cpol = i[1];
        cpha = i[0];
        lsb = i[0];
        wr(SPMC_CR_OFS, 8'h00);
        wr(SPMC_CFG_OFS, 8'h07);
        wr(SPMC_CR_OFS, {lsb, 4'h0, cpha, cpol, 1'h1});
        wr(SPMC_TXR_OFS, tb);
        u_spmc_peer.master_byte(mb, got);
        wait_int();
        check("miso_byte", got, tb);
        // Select release needs the two sync stages to reach the slave
        repeat (3) @(posedge clock);
        #1;
        c1("miso_idle", miso_out, 1'h1);
        rchk(SPMC_RXR_OFS, mb);
        rchk(SPMC_CR_OFS, {lsb, 4'h6, cpha, cpol, 1'h1});
    endtask : sx
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            errors++;
            final_report();
        end
    end
    initial
    begin
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        rchk(SPMC_CR_OFS, 8'h10);
        rchk(SPMC_CFG_OFS, SPMC_CFG_RST);
        c1("int_rst", int_out, 1'h1);
        c1("miso_rst", miso_out, 1'h1);
        c1("sclk_rst", sclk_out, 1'h0);
        for (int i = 0; i < 8; i++)
            mx(i, 1'h1, 1'h0);
        // Second byte lands unread, so overrun must show
        mx(5, 1'h0, 1'h0);
        mx(6, 1'h1, 1'h1);
        rchk(SPMC_TXR_OFS, 8'h00);
        wr(SPMC_RXR_OFS, ~last_rx);
        rchk(SPMC_RXR_OFS, last_rx);
        rchk(8'h30, 8'h00);
        for (int i = 0; i < 4; i++)
            sx(i);
        final_report();
    end
endmodule : testbench
`default_nettype wire
